// >>> src/relay_pkg.sv
// Shared constants for the relay driver channel control logic
package relay_pkg;
  localparam int NCH = 8;
  localparam int FRAME = 16;
  localparam int CNT_W = 8;
  localparam int WR_BIT = 15;
  localparam int ADR_HI = 14;
  localparam int ADR_LO = 12;
  localparam int FS_CH0 = 2;
  localparam int FS_CH1 = 3;
  localparam int HARDWARE_CONTROL_RESET_BIT_BIT = 0;
  localparam int HWCR_UVCLR_BIT = 1;
  localparam int RST_STAGES = 2;

  localparam logic [2:0] ADR_OUT = 3'h0;
  localparam logic [2:0] ADR_MAP0 = 3'h1;
  localparam logic [2:0] ADR_MAP1 = 3'h2;
  localparam logic [2:0] ADR_OLEN = 3'h3;
  localparam logic [2:0] ADR_CLR = 3'h4;
  localparam logic [2:0] ADR_HWCR = 3'h5;

  localparam logic [2:0] RSEL_DIAG = 3'h0;
  localparam logic [2:0] RSEL_OSM = 3'h1;
  localparam logic [2:0] RSEL_OUT = 3'h2;
  localparam logic [2:0] RSEL_MAP = 3'h3;
  localparam logic [2:0] RSEL_OLEN = 3'h4;

  localparam logic [NCH-1:0] OUT_RST = 8'h00;
  localparam logic [NCH-1:0] MAP0_RST = 8'h04;
  localparam logic [NCH-1:0] MAP1_RST = 8'h08;
  localparam logic [NCH-1:0] OLEN_RST = 8'h00;

  localparam int CLK_HZ = 10_000_000;
  localparam int SCLK_MAX_HZ = 5_000_000;
  localparam int RETRY_US = 1000;
  localparam int RETRY_CYC = RETRY_US * (CLK_HZ / 1_000_000);

  // Whole bytes only, at least one full 16-bit word
  function automatic logic frame_len_ok(input logic [CNT_W-1:0] cnt);
    return (cnt >= CNT_W'(FRAME)) && (cnt[2:0] == 3'h0);
  endfunction
endpackage

// >>> src/sync_bank.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
module sync_bank #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule

// >>> src/relay_channel_ctrl.sv
// Channel control, serial port and protection latches of the relay driver
`timescale 1ns/1ns
//
// Contract
// - Control and diagnosis travel in 16-bit serial frames.
// - Shifted data passes through so several devices share one chain.
// - Serial port is dead while the digital supply is absent.
// - Out of reset each direct input drives its own channel.
// - Programmable mapping lets one input switch any set of channels.
// - Fail-safe mode routes inputs to channels 2 and 3, ignoring mapping.
// - Low idle pin lets inputs switch fail-safe channels without digital supply.
// - Overload latches off only that channel until serially reactivated.
// - Fail-safe latched channel with input high restarts after the interval.
// - Per-channel over-temperature latches that channel off.
// - Host enables per-channel open-load test current; monitor bits readable.
// - Diagnosis stays latched until the host clears it or a fail-safe restart clears that channel's latch.
// - Chip select is active low for the whole transfer.
// - Serial output is high impedance while chip select is high.
// - High idle pin puts the device into idle mode.
// - Input zero ties to channel 2, input one to channel 3.
module relay_channel_ctrl #(
  parameter int RETRY_CYCLES = relay_pkg::RETRY_CYC
) (
  input  wire logic                     mclk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     chip_select_low_in,
  input  wire logic                     sclk_in,
  input  wire logic                     sdi_in,
  output logic                          sdo_out,
  output logic                          sdo_oe_out,
  input  wire logic                     direct_input_zero_in,
  input  wire logic                     direct_input_one_in,
  input  wire logic                     idle_in,
  input  wire logic                     vdd_ok_in,
  input  wire logic                     supply_undervoltage_in,
  input  wire logic [relay_pkg::NCH-1:0] overload_in,
  input  wire logic [relay_pkg::NCH-1:0] overtemp_in,
  input  wire logic [relay_pkg::NCH-1:0] output_status_monitor_bits_in,
  output logic      [relay_pkg::NCH-1:0] channel_on_out,
  output logic      [relay_pkg::NCH-1:0] open_load_test_current_out
);
  import relay_pkg::*;

  localparam int RW = $clog2(RETRY_CYCLES + 1);
  localparam int SW = 6 + 3 * NCH;

  typedef struct packed {
    logic             sclk_p;
    logic             csn_p;
    logic [FRAME-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic             so;
    logic             so_oe;
    logic [2:0]       rsel;
    logic [NCH-1:0]   outc;
    logic [NCH-1:0]   map0;
    logic [NCH-1:0]   map1;
    logic [NCH-1:0]   olen;
    logic [NCH-1:0]   ovl;
    logic [NCH-1:0]   ot;
    logic             uv;
    logic [NCH-1:0]   ch_on;
    logic [RW-1:0]    retry;
  } ctrl_state_t;

  localparam ctrl_state_t ST_RST = '{
    sclk_p: 1'b0, csn_p: 1'b1, shift: '0, cnt: '0, so: 1'b0, so_oe: 1'b0,
    rsel: RSEL_DIAG, outc: OUT_RST, map0: MAP0_RST, map1: MAP1_RST,
    olen: OLEN_RST, ovl: '0, ot: '0, uv: 1'b0, ch_on: '0, retry: '0};

  ctrl_state_t st_q;
  ctrl_state_t st_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [SW-1:0] pins_s;
  logic        s_sclk, s_csn, s_si, s_in0, s_in1, s_idle, s_vdd, s_uv;
  logic [NCH-1:0] s_ovl, s_ot, s_osm;
  logic        cs_fall, cs_rise, sclk_rise, sclk_fall, cap, wr, hw_rst, uv_clr;
  logic        fail_safe, fire;
  logic [2:0]  adr;
  logic [NCH-1:0] dat, clr, rclr, fs_in, want, lat, ovl_nx, ot_nx;
  logic [FRAME-1:0] resp;

  // Reset asserts at once, releases only after two clean edges
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  sync_bank #(.W(SW)) u_sync (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .async_in ({sclk_in, ~chip_select_low_in, sdi_in, direct_input_zero_in,
                direct_input_one_in, idle_in, output_status_monitor_bits_in,
                overtemp_in, overload_in}),
    .sync_out (pins_s)
  );
  // Chip select is synchronised inverted so reset flops read as deselected
  assign {s_sclk, s_csn, s_si, s_in0, s_in1, s_idle, s_osm, s_ot, s_ovl} =
    {pins_s[SW-1], ~pins_s[SW-2], pins_s[SW-3:0]};

  // Supply levels pass through their own synchronisers
  logic [1:0] lvl_s;
  sync_bank #(.W(2)) u_sync_lvl (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .async_in ({vdd_ok_in, supply_undervoltage_in}),
    .sync_out (lvl_s)
  );
  assign {s_vdd, s_uv} = lvl_s;

  assign cs_fall   = ~s_csn & st_q.csn_p;
  assign cs_rise   = s_csn & ~st_q.csn_p;
  assign sclk_rise = s_sclk & ~st_q.sclk_p;
  assign sclk_fall = ~s_sclk & st_q.sclk_p;
  assign cap    = cs_rise & s_vdd & frame_len_ok(st_q.cnt);
  assign wr     = cap & st_q.shift[WR_BIT];
  assign adr    = st_q.shift[ADR_HI:ADR_LO];
  assign dat    = st_q.shift[NCH-1:0];
  assign clr    = (wr && adr == ADR_CLR) ? dat : '0;
  assign hw_rst = wr && adr == ADR_HWCR && dat[HARDWARE_CONTROL_RESET_BIT_BIT];
  assign uv_clr = wr && adr == ADR_HWCR && dat[HWCR_UVCLR_BIT];
  assign fail_safe = ~s_vdd & ~s_idle;
  assign lat = st_q.ovl | st_q.ot;

  always_comb begin
    fs_in = '0;
    fs_in[FS_CH0] = s_in0;
    fs_in[FS_CH1] = s_in1;
    case (st_q.rsel)
      RSEL_DIAG: resp = {st_q.ovl, st_q.ot};
      RSEL_OSM:  resp = {st_q.uv, fail_safe, s_idle, 3'h0, s_in1, s_in0, s_osm};
      RSEL_OUT:  resp = {st_q.outc, st_q.ch_on};
      RSEL_MAP:  resp = {st_q.map1, st_q.map0};
      RSEL_OLEN: resp = {st_q.olen, 8'h00};
      default:   resp = 16'h0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    fire = 1'b0;
    st_d.sclk_p = s_sclk;
    st_d.csn_p = s_csn;
    st_d.so_oe = ~s_csn & s_vdd;
    if (!s_vdd) begin
      st_d.cnt = '0;
    end else if (cs_fall) begin
      st_d.shift = resp;
      st_d.so = resp[FRAME-1];
      st_d.cnt = '0;
    end else if (!s_csn) begin
      if (sclk_rise) begin
        // Whatever leaves the top bit reappears downstream after 16 clocks
        st_d.shift = {st_q.shift[FRAME-2:0], s_si};
        if (st_q.cnt != '1) begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      if (sclk_fall) begin
        st_d.so = st_q.shift[FRAME-1];
      end
    end
    if (cap) begin
      if (wr) begin
        case (adr)
          ADR_OUT:  st_d.outc = dat;
          ADR_MAP0: st_d.map0 = dat;
          ADR_MAP1: st_d.map1 = dat;
          ADR_OLEN: st_d.olen = dat;
          default:  st_d.outc = st_q.outc;
        endcase
      end else begin
        st_d.rsel = adr;
      end
    end
    if (hw_rst) begin
      st_d.outc = OUT_RST;
      st_d.map0 = MAP0_RST;
      st_d.map1 = MAP1_RST;
      st_d.olen = OLEN_RST;
      st_d.rsel = RSEL_DIAG;
    end
    // One shared timer; a new latch-off during a run waits the remainder
    if (fail_safe && |(lat & fs_in)) begin
      if (st_q.retry == RW'(RETRY_CYCLES - 1)) begin
        fire = 1'b1;
        st_d.retry = '0;
      end else begin
        st_d.retry = st_q.retry + 1'b1;
      end
    end else begin
      st_d.retry = '0;
    end
    rclr = fire ? (lat & fs_in) : '0;
    // New events win over a clear in the same cycle
    ovl_nx = (st_q.ovl & ~(clr | rclr)) | (s_ovl & st_q.ch_on);
    ot_nx = (st_q.ot & ~(clr | rclr)) | s_ot;
    st_d.ovl = ovl_nx;
    st_d.ot = ot_nx;
    st_d.uv = (st_q.uv & ~uv_clr) | s_uv;
    if (s_idle) begin
      want = '0;
    end else if (fail_safe) begin
      want = fs_in;
    end else begin
      want = st_q.outc | (st_q.map0 & {NCH{s_in0}}) | (st_q.map1 & {NCH{s_in1}});
    end
    st_d.ch_on = want & ~(ovl_nx | ot_nx);
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdo_out = st_q.so;
  assign sdo_oe_out = st_q.so_oe;
  assign channel_on_out = st_q.ch_on;
  assign open_load_test_current_out = st_q.olen;

  sequence s_cs_open;
    $fell(s_csn) && s_vdd;
  endsequence
  sequence s_deselect;
    s_csn || !s_vdd;
  endsequence

  AST_SO_HIZ: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_deselect |=> !sdo_oe_out) else $error("serial output driven while deselected");
  AST_CS_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_cs_open |=> sdo_oe_out && sdo_out == $past(resp[FRAME-1]))
    else $error("response not presented at select");
  // Checks the effect, not the length test itself
  AST_FRAME_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cs_rise && !(st_q.cnt >= 8'h10 && st_q.cnt[2:0] == 3'h0)
      |=> $stable(st_q.outc) && $stable(st_q.map0) && $stable(st_q.map1) && $stable(st_q.olen))
    else $error("bad frame length changed configuration");
  AST_NO_VDD: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !s_vdd |-> !cap ##1 !sdo_oe_out) else $error("serial port active without supply");
  AST_IDLE_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_idle |=> channel_on_out == 8'h00) else $error("channel on in idle");
  AST_OVL_OFF: assert property (@(posedge mclk_in) disable iff (!rst_n)
    |(s_ovl & st_q.ch_on) |=> (channel_on_out & $past(s_ovl & st_q.ch_on)) == 8'h00
      && (st_q.ovl & $past(s_ovl & st_q.ch_on)) == $past(s_ovl & st_q.ch_on))
    else $error("overloaded channel not latched off");
  AST_LATCH_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clr == 8'h00 && !fire |=> (st_q.ovl & $past(st_q.ovl)) == $past(st_q.ovl))
    else $error("overload latch lost without clear");
  AST_OT_LATCH: assert property (@(posedge mclk_in) disable iff (!rst_n)
    |s_ot |=> (st_q.ot & $past(s_ot)) == $past(s_ot) && (channel_on_out & $past(s_ot)) == 8'h00)
    else $error("over-temperature not latched");
  AST_FS_ROUTE: assert property (@(posedge mclk_in) disable iff (!rst_n)
    fail_safe && lat == 8'h00 && (s_ovl | s_ot) == 8'h00
      |=> channel_on_out == $past({4'h0, s_in1, s_in0, 2'h0}))
    else $error("fail-safe routing wrong");
  AST_MAP: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !fail_safe && !s_idle && lat == 8'h00 && (s_ovl | s_ot) == 8'h00
      |=> channel_on_out == $past(st_q.outc | (st_q.map0 & {NCH{s_in0}})
                                  | (st_q.map1 & {NCH{s_in1}})))
    else $error("mapped channel state wrong");
  AST_RETRY: assert property (@(posedge mclk_in) disable iff (!rst_n)
    fire |=> (st_q.ovl & $past(lat & fs_in & ~s_ovl & ~s_ot)) == 8'h00)
    else $error("fail-safe restart did not clear latch");
endmodule

// >>> tb/serial_host.sv
// Serial host model driving framed transfers into the relay driver
`timescale 1ns/1ns
module serial_host (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      chip_select_low_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  initial begin
    chip_select_low_out = 1'b1;
    sclk_out            = 1'b0;
    sdi_out             = 1'b0;
  end

  // Clock stands low outside frames; 4-cycle phases stay far below the max rate
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge clk_in);
    #10 chip_select_low_out = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      repeat (4) @(posedge clk_in);
      #10 sclk_out = 1'b1;
      rx = {rx[30:0], sdo_in};
      repeat (4) @(posedge clk_in);
      #10 sclk_out = 1'b0;
    end
    sdi_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #10 chip_select_low_out = 1'b1;
    repeat (5) @(posedge clk_in);
    // Return off the edge so callers drive and sample settled values
    #10;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the relay channel control block
`timescale 1ns/1ns
module testbench;
  logic        mclk, resetn, zero_pin, one_pin, idle, vdd, uv;
  logic [7:0]  ovl, ot, osm;
  logic        chip_select_low, sclk, sdi, sdo, sdo_oe;
  logic [7:0]  chan, olt;
  logic [31:0] r;
  wire         sdo_line;
  int          error_cnt, checks_done, cyc_cnt;

  assign sdo_line = sdo_oe ? sdo : 1'bz;

  relay_channel_ctrl #(.RETRY_CYCLES(20)) dut (
    .mclk_in(mclk), .resetn_in(resetn), .chip_select_low_in(chip_select_low), .sclk_in(sclk),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .direct_input_zero_in(zero_pin),
    .direct_input_one_in(one_pin), .idle_in(idle), .vdd_ok_in(vdd),
    .supply_undervoltage_in(uv), .overload_in(ovl), .overtemp_in(ot),
    .output_status_monitor_bits_in(osm), .channel_on_out(chan),
    .open_load_test_current_out(olt));

  serial_host host (.clk_in(mclk), .sdo_in(sdo_line), .chip_select_low_out(chip_select_low),
    .sclk_out(sclk), .sdi_out(sdi));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 4000 cycles the sequence needs
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask

  task automatic wr(input logic [15:0] f);
    logic [31:0] x;
    host.xfer({16'h0, f}, 16, x);
  endtask

  // Response of a read shows up in the frame after the one that selects it
  task automatic rd(input logic [2:0] sel, output logic [31:0] rx);
    host.xfer({17'h0, sel, 12'h0}, 16, rx);
    host.xfer({17'h0, sel, 12'h0}, 16, rx);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    {resetn, zero_pin, one_pin, idle, uv, ovl, ot, osm} = '0;
    vdd = 1'b1;
    cyc(3);
    resetn = 1'b1;
    cyc(6);
    zero_pin = 1'b1;
    cyc(5);
    chk(chan, 8'h04);
    {zero_pin, one_pin} = 2'b01;
    cyc(5);
    chk(chan, 8'h08);
    one_pin = 1'b0;
    tend("defaults");
    wr(16'h80A5);
    chk(chan, 8'hA5);
    chk(sdo_oe, 1'b0);
    host.xfer(32'h80FF, 12, r);
    chk(chan, 8'hA5);
    host.xfer(32'hFF805A, 24, r);
    chk(chan, 8'h5A);
    host.xfer(32'h80C38033, 32, r);
    chk(r[15:0], 16'h80C3);
    chk(chan, 8'h33);
    tend("frames");
    wr(16'h9081);
    zero_pin = 1'b1;
    cyc(5);
    chk(chan, 8'hB3);
    zero_pin = 1'b0;
    ovl = 8'h01;
    cyc(6);
    ovl = 8'h00;
    cyc(6);
    chk(chan, 8'h32);
    ot = 8'h20;
    cyc(6);
    ot = 8'h00;
    cyc(6);
    chk(chan, 8'h12);
    rd(3'h0, r);
    chk(r[15:0], 16'h0120);
    wr(16'hC021);
    chk(chan, 8'h33);
    rd(3'h0, r);
    chk(r[15:0], 16'h0000);
    tend("latches");
    wr(16'hB03C);
    chk(olt, 8'h3C);
    osm = 8'h5A;
    rd(3'h1, r);
    chk(r[15:0], 16'h005A);
    tend("open_load");
    idle = 1'b1;
    cyc(5);
    chk(chan, 8'h00);
    idle = 1'b0;
    vdd = 1'b0;
    {zero_pin, one_pin} = 2'b11;
    cyc(5);
    chk(chan, 8'h0C);
    fork
      wr(16'h80FF);
      begin
        cyc(20);
        chk(sdo_oe, 1'b0);
      end
    join
    chk(chan, 8'h0C);
    ovl = 8'h04;
    cyc(6);
    ovl = 8'h00;
    chk(chan, 8'h08);
    cyc(30);
    chk(chan, 8'h0C);
    vdd = 1'b1;
    cyc(6);
    chk(chan, 8'hBB);
    tend("fail_safe");
    uv = 1'b1;
    cyc(5);
    uv = 1'b0;
    cyc(5);
    rd(3'h1, r);
    chk(r[15:0], 16'h835A);
    wr(16'hD002);
    rd(3'h1, r);
    chk(r[15:0], 16'h035A);
    rd(3'h2, r);
    chk(r[15:0], 16'h33BB);
    rd(3'h4, r);
    chk(r[15:0], 16'h3C00);
    rd(3'h3, r);
    chk(r[15:0], 16'h0881);
    wr(16'hD001);
    chk(chan, 8'h0C);
    chk(olt, 8'h00);
    rd(3'h3, r);
    chk(r[15:0], 16'h0804);
    tend("control");
    final_report;
  end
endmodule
